// *** pkg/vpit_arb_if.sv ***
// carrier between the request collector and the level arbiter
interface vpit_arb_if;
    logic [vpit_pkg::NUM_VEC-1:0]                      pend;
    logic [vpit_pkg::NUM_VEC-1:0][vpit_pkg::LVL_W-1:0] lvl;
    logic                                              hit;
    logic [vpit_pkg::VEC_W-1:0]                        win_vec;
    logic [vpit_pkg::LVL_W-1:0]                        win_lvl;

    modport collector (
        output pend,
        output lvl,
        input  hit,
        input  win_vec,
        input  win_lvl
    );
    modport arbiter (
        input  pend,
        input  lvl,
        output hit,
        output win_vec,
        output win_lvl
    );
endinterface : vpit_arb_if

// *** pkg/vpit_pkg.sv ***
// constants and state type for the vectored priority interrupt table
package vpit_pkg;
    // table shape
    localparam int NUM_VEC = 59;
    localparam int VEC_W   = 6;
    localparam int LVL_W   = 2;
    localparam int ADDR_W  = 21;
    // each entry spans two words
    localparam int ENTRY_SHIFT = 1;

    // base after reset, so entries 0 and 1 overlay the reset addresses
    localparam logic [ADDR_W-1:0] BASE_RST = 21'h000000;

    // fixed entries
    localparam int VEC_CHIP_RESET  = 0;
    localparam int VEC_WDOG_RESET  = 1;
    localparam int VEC_CORE_EXC    = 2;
    localparam int VEC_DEBUG       = 6;
    localparam int VEC_SWI_LOW     = 11;
    localparam int VEC_LOW_VOLTAGE = 14;
    localparam int VEC_CLOCK_LOSS  = 15;

    // peripheral entries
    localparam int VEC_PERIPH      = 16;
    localparam int VEC_TIMER_B     = 16;
    localparam int VEC_ADC         = 20;
    localparam int VEC_CAN         = 23;
    localparam int VEC_SERIAL1     = 27;
    localparam int VEC_SERIAL0     = 31;
    localparam int VEC_SPI         = 35;
    localparam int VEC_I2C         = 37;
    localparam int VEC_TIMER_A     = 39;
    localparam int VEC_PWM         = 43;
    localparam int VEC_FLASH       = 54;
    localparam int VEC_COMPARATOR  = 57;
    localparam int NUM_PERIPH      = NUM_VEC - VEC_PERIPH;

    // levels
    localparam logic [LVL_W-1:0] LVL_0 = 2'h0;
    localparam logic [LVL_W-1:0] LVL_1 = 2'h1;
    localparam logic [LVL_W-1:0] LVL_2 = 2'h2;
    localparam logic [LVL_W-1:0] LVL_3 = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] base;
        logic              valid;
        logic [VEC_W-1:0]  vec;
        logic [LVL_W-1:0]  lvl;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] rst_addr;
        logic [ADDR_W-1:0] wdog_addr;
    } vpit_state_t;
endpackage : vpit_pkg

// *** tb/tb_vpit_top.sv ***
// self-checking bench for the vectored priority interrupt table
module tb_vpit_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NV = vpit_pkg::NUM_VEC;
    localparam int LW = 2 * NV;
    logic                        mclk_in = 1'b0;
    logic                        rst_in = 1'b1;
    logic                        base_load_in = 1'b0;
    logic [vpit_pkg::ADDR_W-1:0] base_value_in = '0;
    logic [vpit_pkg::ADDR_W-1:0] base_x = '0;
    logic [NV-1:0]               pend = '0;
    logic [NV-1:0][1:0]          lv = '0;
    logic [31:0]                 seed = 32'h5D0740BC;
    int                          miscompares = 0;
    int                          compares = 0;
    int                          cyc = 0;
    wire logic [3:0]             core_exc_req_in = pend[5:2];
    wire logic [4:0]             debug_req_in = pend[10:6];
    wire logic [4:0][1:0]        debug_level_in = lv[10:6];
    wire logic [2:0]             swi_low_req_in = pend[13:11];
    wire logic                   low_voltage_req_in = pend[14];
    wire logic [1:0]             low_voltage_level_in = lv[14];
    wire logic                   clock_loss_req_in = pend[15];
    wire logic [1:0]             clock_loss_level_in = lv[15];
    wire logic [3:0]             timer_b_req_in = {pend[16], pend[17], pend[18], pend[19]};
    wire logic [2:0]             adc_req_in = pend[22:20];
    wire logic [3:0]             can_req_in = pend[26:23];
    wire logic [3:0]             serial1_req_in = pend[30:27];
    wire logic [3:0]             serial0_req_in = pend[34:31];
    wire logic [1:0]             spi_req_in = pend[36:35];
    wire logic [1:0]             i2c_req_in = pend[38:37];
    wire logic [3:0]             timer_a_req_in = {pend[39], pend[40], pend[41], pend[42]};
    wire logic [10:0]            pwm_req_in = pend[53:43];
    wire logic [2:0]             flash_req_in = pend[56:54];
    wire logic [1:0]             comparator_req_in = pend[58:57];
    wire logic [42:0][1:0]       periph_level_in = lv[58:16];
    logic                        irq_valid_out;
    logic [5:0]                  irq_vector_out;
    logic [1:0]                  irq_level_out;
    logic [20:0]                 irq_vector_addr_out;
    logic [20:0]                 chip_reset_addr_out;
    logic [20:0]                 watchdog_reset_addr_out;
    logic                        jump;

    vpit_top i_vpit_top (.mclk_in, .rst_in, .base_load_in, .base_value_in, .core_exc_req_in, .debug_req_in,
        .debug_level_in, .swi_low_req_in, .low_voltage_req_in, .low_voltage_level_in, .clock_loss_req_in,
        .clock_loss_level_in, .timer_b_req_in, .adc_req_in, .can_req_in, .serial1_req_in, .serial0_req_in,
        .spi_req_in, .i2c_req_in, .timer_a_req_in, .pwm_req_in, .flash_req_in, .comparator_req_in,
        .periph_level_in, .irq_valid_out, .irq_vector_out, .irq_level_out, .irq_vector_addr_out,
        .chip_reset_addr_out, .watchdog_reset_addr_out);
    vpit_core_model i_vpit_core_model (.irq_valid_in(irq_valid_out), .vec_addr_in(irq_vector_addr_out),
        .base_addr_in(chip_reset_addr_out), .jump_out(jump));

    always begin
        #2 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            close_out();
        end
    end

    function automatic logic [31:0] nx();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
        return seed;
    endfunction : nx
    // effective level of a vector after clamping
    function automatic logic [1:0] eff(int v, logic [1:0] l);
        if (v < 6) return 2'h3;
        if (v >= 11 && v <= 13) return 2'(13 - v);
        if (v < 16) return (l == 2'h0) ? 2'h1 : l;
        return (l == 2'h3) ? 2'h2 : l;
    endfunction : eff
    function automatic int win();
        int w;
        w = 0;
        for (int v = 2; v < NV; v++)
            if (pend[v] && (w == 0 || eff(v, lv[v]) > eff(w, lv[w]))) w = v;
        return w;
    endfunction : win

    task automatic chk_win(input logic ev, input logic [5:0] evec, input logic [1:0] elv);
        compares++;
        if (irq_valid_out !== ev || jump !== !ev || (ev && (irq_vector_out !== evec || irq_level_out !== elv))) begin
            miscompares++;
            $display("[ERR] %0t winner %b/%0d/%0d exp %b/%0d/%0d", $time, irq_valid_out, irq_vector_out,
                irq_level_out, ev, evec, elv);
        end
    endtask : chk_win
    task automatic chk_addr(input logic [20:0] got, input logic [20:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t address %h exp %h", $time, got, exp);
        end
    endtask : chk_addr
    task automatic step();
        int w;
        w = win();
        @(negedge mclk_in);
        chk_win(|pend[NV-1:2], 6'(w), eff(w, lv[w]));
        if (w > 0) chk_addr(irq_vector_addr_out, base_x + 21'(2 * w));
    endtask : step
    task automatic close_out();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    initial begin
        repeat (10) @(negedge mclk_in);
        rst_in = 1'b0;
        chk_win(1'b0, 6'h00, 2'h0);
        chk_addr(chip_reset_addr_out, 21'h000000);
        chk_addr(watchdog_reset_addr_out, 21'h000002);
        $display("reset test done");
        for (int v = 2; v < NV; v++) begin
            pend = '0;
            pend[v] = 1'b1;
            lv[v] = 2'(v);
            step();
        end
        $display("vector walk done");
        repeat (400) begin
            pend = NV'({nx(), nx()} & {nx(), nx()});
            lv = LW'({nx(), nx(), nx(), nx()});
            if (seed[2:0] == 3'h0) pend = '0;
            step();
        end
        $display("random test done");
        pend = '0;
        pend[58] = 1'b1;
        lv[58] = 2'h3;
        base_load_in = 1'b1;
        base_value_in = 21'h1FFFF0;
        step();
        base_x = 21'h1FFFF0;
        base_value_in = 21'h000400;
        step();
        base_x = 21'h000400;
        base_load_in = 1'b0;
        step();
        chk_addr(watchdog_reset_addr_out, 21'h000402);
        chk_addr(chip_reset_addr_out, 21'h000400);
        $display("base test done");
        // reset in mid-run must drop a loaded base back to its reset value
        rst_in = 1'b1;
        @(negedge mclk_in);
        rst_in = 1'b0;
        chk_win(1'b0, 6'h00, 2'h0);
        chk_addr(chip_reset_addr_out, 21'h000000);
        chk_addr(watchdog_reset_addr_out, 21'h000002);
        $display("second reset test done");
        close_out();
    end
endmodule : tb_vpit_top

// *** tb/vpit_core_model.sv ***
// core side model that fetches the entry of each dispatched vector
module vpit_core_model (
    // dispatch seen from the core
    input  wire logic                        irq_valid_in,
    input  wire logic [vpit_pkg::ADDR_W-1:0] vec_addr_in,
    input  wire logic [vpit_pkg::ADDR_W-1:0] base_addr_in,
    // fetched entry is a jump, not a call
    output logic                             jump_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [vpit_pkg::ADDR_W-1:0] off;
    // with nothing dispatched the core fetches the chip reset entry
    assign off = irq_valid_in ? vec_addr_in - base_addr_in : '0;
    // two reset entries hold jumps, every other entry a call
    assign jump_out = off < 21'h000004;
endmodule : vpit_core_model

// *** tb/vpit_top_chk.sv ***
// concurrent checks on the dispatch ports of the interrupt table
module vpit_top_chk (
    // clock and reset
    input wire logic                        mclk_in,
    input wire logic                        rst_in,
    // inputs watched
    input wire logic                        base_load_in,
    input wire logic [vpit_pkg::ADDR_W-1:0] base_value_in,
    input wire logic [3:0]                  core_exc_req_in,
    // outputs watched
    input wire logic                        irq_valid_out,
    input wire logic [vpit_pkg::VEC_W-1:0]  irq_vector_out,
    input wire logic [vpit_pkg::LVL_W-1:0]  irq_level_out,
    input wire logic [vpit_pkg::ADDR_W-1:0] irq_vector_addr_out,
    input wire logic [vpit_pkg::ADDR_W-1:0] chip_reset_addr_out,
    input wire logic [vpit_pkg::ADDR_W-1:0] watchdog_reset_addr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    exc_top_a: assert property (core_exc_req_in != 4'h0 |=> irq_valid_out && irq_level_out == 2'h3)
        else $error("exception not served at top level");
    exc_low_a: assert property (core_exc_req_in[0] |=> irq_vector_out == 6'h02)
        else $error("lowest exception vector lost");
    exc_last_a: assert property (core_exc_req_in == 4'h8 |=> irq_vector_out == 6'h05)
        else $error("misaligned access vector wrong");
    addr_form_a: assert property (irq_valid_out |->
        irq_vector_addr_out == chip_reset_addr_out + {irq_vector_out, 1'b0})
        else $error("vector address not base plus twice vector");
    wdog_gap_a: assert property (watchdog_reset_addr_out == chip_reset_addr_out + 21'h000002)
        else $error("watchdog entry not two above reset entry");
    base_load_a: assert property (base_load_in |-> ##2 chip_reset_addr_out == $past(base_value_in, 2))
        else $error("loaded base not used");
    rst_clear_a: assert property (disable iff (1'b0) rst_in |=> !irq_valid_out && chip_reset_addr_out == 21'h000000)
        else $error("reset base or valid wrong");
    fixed_lvl_a: assert property (irq_valid_out && irq_vector_out inside {[6'h02:6'h05]} |-> irq_level_out == 2'h3)
        else $error("core exception level wrong");
    debug_lvl_a: assert property (irq_valid_out && irq_vector_out inside {[6'h06:6'h0A], 6'h0E, 6'h0F}
        |-> irq_level_out != 2'h0)
        else $error("programmable level below one");
    periph_lvl_a: assert property (irq_valid_out && irq_vector_out >= 6'h10 |-> irq_level_out != 2'h3)
        else $error("peripheral level above two");
endmodule : vpit_top_chk

bind vpit_top vpit_top_chk i_vpit_top_chk (.mclk_in, .rst_in, .base_load_in, .base_value_in,
    .core_exc_req_in, .irq_valid_out, .irq_vector_out, .irq_level_out, .irq_vector_addr_out,
    .chip_reset_addr_out, .watchdog_reset_addr_out);

// *** verilog/vpit_arbiter.sv ***
// combinational winner selection: highest level, then lowest vector
module vpit_arbiter (
    vpit_arb_if.arbiter arb_if
);
    logic [3:0]                       lvl_hit;
    logic [3:0][vpit_pkg::VEC_W-1:0]  lvl_idx;

    // per level, the lowest pending vector at that level
    for (genvar g = 0; g < 4; g++) begin : g_level
        always_comb begin
            lvl_hit[g] = 1'b0;
            lvl_idx[g] = '0;
            for (int v = vpit_pkg::NUM_VEC - 1; v >= 0; v--) begin
                if (arb_if.pend[v] && (arb_if.lvl[v] == 2'(g))) begin
                    lvl_hit[g] = 1'b1;
                    lvl_idx[g] = 6'(v);
                end
            end
        end
    end

    // higher level served ahead of every lower one
    always_comb begin
        arb_if.hit     = 1'b0;
        arb_if.win_vec = '0;
        arb_if.win_lvl = vpit_pkg::LVL_0;
        for (int l = 0; l < 4; l++) begin
            if (lvl_hit[l]) begin
                arb_if.hit     = 1'b1;
                arb_if.win_vec = lvl_idx[l];
                arb_if.win_lvl = 2'(l);
            end
        end
    end
endmodule : vpit_arbiter

// *** verilog/vpit_top.sv ***
// vectored priority interrupt table: request collection, level mapping, vector dispatch
//
// Notes on behaviour
// - Every pending request at a higher level is served before any request at a lower level.
// - Within one level the pending request with the smallest vector number wins.
// - The table sits at a loadable base and every vector address is formed from that base.
// - Chip reset and watchdog reset entries are vectors 0 and 1, at base offsets zero and two.
// - Core exceptions use vectors 2 to 5 at level 3; software interrupts 0, 1, 2 use 11, 12, 13 at levels 2, 1, 0.
// - Debug unit requests use vectors 6 to 10, each with a level from 1 to 3.
// - Low voltage uses vector 14 and clock loss uses vector 15, each with a level from 1 to 3.
// - Every peripheral request, vectors 16 onward, takes only a level from 0 to 2.
// - Timer group B channels 3 to 0 use vectors 16 to 19; group A channels 3 to 0 use 39 to 42.
// - PWM fault 43, reload error 44, sub-module 3 reload/capture/compare 45-47, others 48-53.
// - Flash access error, command complete and buffer empty use vectors 54, 55 and 56.
// - Comparators C and B raise combined edge flags at vectors 57 and 58.
// - Each entry spans two words, so vector n lies at base plus twice n.
// - With the base at its reset value the first two entries fall on the reset addresses.
module vpit_top (
    // clock and reset
    input  wire logic                                      mclk_in,
    input  wire logic                                      rst_in,
    // table base load
    input  wire logic                                      base_load_in,
    input  wire logic [vpit_pkg::ADDR_W-1:0]               base_value_in,
    // core requests
    input  wire logic [3:0]                                core_exc_req_in,
    input  wire logic [4:0]                                debug_req_in,
    input  wire logic [4:0][vpit_pkg::LVL_W-1:0]           debug_level_in,
    input  wire logic [2:0]                                swi_low_req_in,
    // supervisor requests
    input  wire logic                                      low_voltage_req_in,
    input  wire logic [vpit_pkg::LVL_W-1:0]                low_voltage_level_in,
    input  wire logic                                      clock_loss_req_in,
    input  wire logic [vpit_pkg::LVL_W-1:0]                clock_loss_level_in,
    // peripheral requests
    input  wire logic [3:0]                                timer_b_req_in,
    input  wire logic [2:0]                                adc_req_in,
    input  wire logic [3:0]                                can_req_in,
    input  wire logic [3:0]                                serial1_req_in,
    input  wire logic [3:0]                                serial0_req_in,
    input  wire logic [1:0]                                spi_req_in,
    input  wire logic [1:0]                                i2c_req_in,
    input  wire logic [3:0]                                timer_a_req_in,
    input  wire logic [10:0]                               pwm_req_in,
    input  wire logic [2:0]                                flash_req_in,
    input  wire logic [1:0]                                comparator_req_in,
    input  wire logic [vpit_pkg::NUM_PERIPH-1:0][1:0]      periph_level_in,
    // dispatch to core
    output logic                                           irq_valid_out,
    output logic [vpit_pkg::VEC_W-1:0]                     irq_vector_out,
    output logic [vpit_pkg::LVL_W-1:0]                     irq_level_out,
    output logic [vpit_pkg::ADDR_W-1:0]                    irq_vector_addr_out,
    // reset entry addresses
    output logic [vpit_pkg::ADDR_W-1:0]                    chip_reset_addr_out,
    output logic [vpit_pkg::ADDR_W-1:0]                    watchdog_reset_addr_out
);
    vpit_arb_if          arb_if ();
    vpit_pkg::vpit_state_t state_q;
    vpit_pkg::vpit_state_t state_d;

    logic [vpit_pkg::NUM_VEC-1:0][vpit_pkg::LVL_W-1:0] cfg_level;
    logic [vpit_pkg::NUM_VEC-1:0]                      pend;

    // level a vector actually takes, given its class and programmed value
    function automatic logic [vpit_pkg::LVL_W-1:0] eff_level(
        input logic [vpit_pkg::VEC_W-1:0] vec,
        input logic [vpit_pkg::LVL_W-1:0] cfg
    );
        logic [vpit_pkg::LVL_W-1:0] res;
        res = cfg;
        if (vec < 6'(vpit_pkg::VEC_DEBUG)) begin
            res = vpit_pkg::LVL_3;
        end else if (vec == 6'(vpit_pkg::VEC_SWI_LOW)) begin
            res = vpit_pkg::LVL_2;
        end else if (vec == 6'(vpit_pkg::VEC_SWI_LOW + 1)) begin
            res = vpit_pkg::LVL_1;
        end else if (vec == 6'(vpit_pkg::VEC_SWI_LOW + 2)) begin
            res = vpit_pkg::LVL_0;
        end else if (vec < 6'(vpit_pkg::VEC_PERIPH)) begin
            // level 0 is not available here, lifted to 1
            if (cfg == vpit_pkg::LVL_0) begin
                res = vpit_pkg::LVL_1;
            end
        end else begin
            // level 3 is not available here, held at 2
            if (cfg == vpit_pkg::LVL_3) begin
                res = vpit_pkg::LVL_2;
            end
        end
        return res;
    endfunction : eff_level

    // vector address: two words per entry
    function automatic logic [vpit_pkg::ADDR_W-1:0] entry_addr(
        input logic [vpit_pkg::ADDR_W-1:0] base,
        input logic [vpit_pkg::VEC_W-1:0]  vec
    );
        logic [vpit_pkg::ADDR_W-1:0] off;
        off = vpit_pkg::ADDR_W'(vec) << vpit_pkg::ENTRY_SHIFT;
        return base + off;
    endfunction : entry_addr

    // gather requests into vector order
    always_comb begin
        pend      = '0;
        cfg_level = '0;
        pend[vpit_pkg::VEC_CORE_EXC +: 4] = core_exc_req_in;
        for (int i = 0; i < 5; i++) begin
            pend[vpit_pkg::VEC_DEBUG + i]      = debug_req_in[i];
            cfg_level[vpit_pkg::VEC_DEBUG + i] = debug_level_in[i];
        end
        pend[vpit_pkg::VEC_SWI_LOW +: 3] = swi_low_req_in;
        pend[vpit_pkg::VEC_LOW_VOLTAGE]      = low_voltage_req_in;
        cfg_level[vpit_pkg::VEC_LOW_VOLTAGE] = low_voltage_level_in;
        pend[vpit_pkg::VEC_CLOCK_LOSS]       = clock_loss_req_in;
        cfg_level[vpit_pkg::VEC_CLOCK_LOSS]  = clock_loss_level_in;
        // timer channels count down as vectors count up
        for (int c = 0; c < 4; c++) begin
            pend[vpit_pkg::VEC_TIMER_B + 3 - c] = timer_b_req_in[c];
            pend[vpit_pkg::VEC_TIMER_A + 3 - c] = timer_a_req_in[c];
        end
        pend[vpit_pkg::VEC_ADC +: 3]     = adc_req_in;
        pend[vpit_pkg::VEC_CAN +: 4]     = can_req_in;
        pend[vpit_pkg::VEC_SERIAL1 +: 4] = serial1_req_in;
        pend[vpit_pkg::VEC_SERIAL0 +: 4] = serial0_req_in;
        pend[vpit_pkg::VEC_SPI +: 2]     = spi_req_in;
        pend[vpit_pkg::VEC_I2C +: 2]     = i2c_req_in;
        pend[vpit_pkg::VEC_PWM +: 11]    = pwm_req_in;
        pend[vpit_pkg::VEC_FLASH +: 3]   = flash_req_in;
        pend[vpit_pkg::VEC_COMPARATOR +: 2] = comparator_req_in;
        for (int p = 0; p < vpit_pkg::NUM_PERIPH; p++) begin
            cfg_level[vpit_pkg::VEC_PERIPH + p] = periph_level_in[p];
        end
    end

    // hand requests with their resolved levels to the arbiter
    always_comb begin
        arb_if.pend = pend;
        for (int v = 0; v < vpit_pkg::NUM_VEC; v++) begin
            arb_if.lvl[v] = eff_level(6'(v), cfg_level[v]);
        end
    end

    vpit_arbiter u_arbiter (
        .arb_if (arb_if.arbiter)
    );

    // next state
    always_comb begin
        state_d = state_q;
        if (base_load_in) begin
            state_d.base = base_value_in;
        end
        // winner re-evaluated from this cycle's requests
        state_d.valid = arb_if.hit;
        state_d.vec   = arb_if.win_vec;
        state_d.lvl   = arb_if.win_lvl;
        state_d.addr  = entry_addr(state_q.base, arb_if.win_vec);
        state_d.rst_addr  = entry_addr(state_q.base, 6'(vpit_pkg::VEC_CHIP_RESET));
        state_d.wdog_addr = entry_addr(state_q.base, 6'(vpit_pkg::VEC_WDOG_RESET));
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_q.base      <= vpit_pkg::BASE_RST;
            state_q.valid     <= 1'b0;
            state_q.vec       <= '0;
            state_q.lvl       <= vpit_pkg::LVL_0;
            state_q.addr      <= vpit_pkg::BASE_RST;
            state_q.rst_addr  <= vpit_pkg::BASE_RST;
            state_q.wdog_addr <= entry_addr(vpit_pkg::BASE_RST, 6'(vpit_pkg::VEC_WDOG_RESET));
        end else begin
            state_q <= state_d;
        end
    end

    // outputs straight from the state register
    assign irq_valid_out           = state_q.valid;
    assign irq_vector_out          = state_q.vec;
    assign irq_level_out           = state_q.lvl;
    assign irq_vector_addr_out     = state_q.addr;
    assign chip_reset_addr_out     = state_q.rst_addr;
    assign watchdog_reset_addr_out = state_q.wdog_addr;
endmodule : vpit_top
